// ---- core/usrp_pins.sv ----
// Reset, suspend, power and activity pin control of the serial bridge
`timescale 1ns/1ns
module usrp_pins
   import usrp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ext_reset_n,
   input wire logic ring_indicate_n,
   input wire logic power_mode_strap,
   input wire logic cfg_mem_select_i,
   input wire logic cfg_mem_io_i,
   input wire logic test_mode,
   input wire logic osc_in,
   input wire logic usb_suspended,
   input wire logic usb_configured,
   input wire logic usb_bus_reset,
   input wire logic usb_tx_event,
   input wire logic usb_rx_event,
   input wire logic remote_wake_en,
   input wire logic mem_sel_drv,
   input wire logic mem_clk_drv,
   input wire logic mem_io_drv,
   input wire logic mem_io_oe_req,
   input wire logic uart_tx_busy,
   output usrp_pkg::usrp_mem_pins_s mem_pins,
   output logic cfg_mem_io_rd,
   output logic device_reset,
   output logic clk48_mode,
   output logic self_powered,
   output logic resume_req,
   output logic sleep_n,
   output logic power_enable_n,
   output logic reset_gen_out_n_o,
   output logic reset_gen_out_n_oe,
   output logic tx_activity_led_n_o,
   output logic tx_activity_led_n_oe,
   output logic rx_activity_led_n_o,
   output logic rx_activity_led_n_oe,
   output logic osc_out,
   output logic rs485_drive_enable
);
   import usrp_pkg::*;

   localparam logic [CNT_W-1:0] RG_LAST = CNT_W'(RSTGEN_CYCLES - 1);
   localparam logic [CNT_W-1:0] LED_LOAD = CNT_W'(LED_CYCLES);

   usrp_state_s st_r;
   usrp_state_s st_nxt;
   logic in_reset;

   function automatic usrp_sync_s sync_step(input usrp_sync_s s, input logic pin);
      usrp_sync_s n;
      n.s1 = pin;
      n.s2 = s.s1;
      n.s3 = s.s2;
      n.val = (s.s2 == s.s3) ? s.s3 : s.val;
      return n;
   endfunction

   function automatic logic [CNT_W-1:0] lamp_step(input logic [CNT_W-1:0] c, input logic ev);
      if (ev) begin
         return LED_LOAD;
      end
      return (c != '0) ? c - CNT_W'(1) : c;
   endfunction

   // Filtered external reset holds the core; the test input keeps it out of normal work
   // Test pin is filtered too, so a glitch on it cannot drop the block into reset
   assign in_reset = srst || !st_r.reset_n.val || st_r.test_in.val;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.reset_n = sync_step(st_r.reset_n, ext_reset_n);
      st_nxt.ring_n = sync_step(st_r.ring_n, ring_indicate_n);
      st_nxt.pwr_strap = sync_step(st_r.pwr_strap, power_mode_strap);
      st_nxt.test_in = sync_step(st_r.test_in, test_mode);
      st_nxt.self_powered = st_r.pwr_strap.val;
      st_nxt.tx_cnt = lamp_step(st_r.tx_cnt, usb_tx_event);
      st_nxt.rx_cnt = lamp_step(st_r.rx_cnt, usb_rx_event);
      // Bus reset is not an input to this machine at all
      case (st_r.rg_state)
         USRP_RG_HOLD: begin
            st_nxt.rg_cnt = '0;
            if (!in_reset) begin
               st_nxt.rg_state = USRP_RG_WAIT;
            end
         end
         USRP_RG_WAIT: begin
            st_nxt.rg_cnt = st_r.rg_cnt + CNT_W'(1);
            if (st_r.rg_cnt == RG_LAST) begin
               st_nxt.rg_state = USRP_RG_DRIVE;
            end
         end
         USRP_RG_DRIVE: begin
            st_nxt.rg_cnt = st_r.rg_cnt;
         end
         default: begin
            st_nxt.rg_state = USRP_RG_HOLD;
         end
      endcase
      if (in_reset) begin
         st_nxt.rg_state = USRP_RG_HOLD;
         st_nxt.strap_taken = 1'b0;
         st_nxt.configured = 1'b0;
         st_nxt.wake_done = 1'b0;
         st_nxt.resume_req = 1'b0;
      end else begin
         // Select stays released until the strap is taken, so only the board pull is read
         if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            st_nxt.clk48_mode = !cfg_mem_select_i;
         end
         if (usb_suspended) begin
            st_nxt.configured = 1'b0;
         end else if (usb_configured) begin
            st_nxt.configured = 1'b1;
         end
         // One resume request per suspend; re-armed when the link wakes
         st_nxt.resume_req = 1'b0;
         if (!usb_suspended) begin
            st_nxt.wake_done = 1'b0;
         end else if (remote_wake_en && !st_r.ring_n.val && !st_r.wake_done) begin
            st_nxt.resume_req = 1'b1;
            st_nxt.wake_done = 1'b1;
         end
      end
      st_nxt.osc_gate = !usb_suspended;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_r <= '{reset_n: '{1'b1, 1'b1, 1'b1, 1'b1}, ring_n: '{1'b1, 1'b1, 1'b1, 1'b1},
                   pwr_strap: '0, rg_state: USRP_RG_HOLD, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mem_pins.sel_o = mem_sel_drv;
      mem_pins.sel_oe = !in_reset && st_r.strap_taken;
      mem_pins.clk_o = mem_clk_drv;
      mem_pins.clk_oe = !in_reset;
      mem_pins.io_o = mem_io_drv;
      mem_pins.io_oe = !in_reset && mem_io_oe_req;
   end
   assign cfg_mem_io_rd = cfg_mem_io_i;
   assign device_reset = in_reset;
   assign clk48_mode = st_r.clk48_mode;
   assign self_powered = st_r.self_powered;
   assign resume_req = st_r.resume_req;
   assign sleep_n = !usb_suspended;
   assign power_enable_n = !st_r.configured || usb_suspended;
   assign reset_gen_out_n_o = 1'b1;
   assign reset_gen_out_n_oe = (st_r.rg_state == USRP_RG_DRIVE);
   // Open-drain lamps only ever pull low
   assign tx_activity_led_n_o = 1'b0;
   assign tx_activity_led_n_oe = (st_r.tx_cnt != '0);
   assign rx_activity_led_n_o = 1'b0;
   assign rx_activity_led_n_oe = (st_r.rx_cnt != '0);
   // Gate is a flop fed from the suspend level; a glitch-free cell belongs in the pad ring
   assign osc_out = osc_in && st_r.osc_gate;
   assign rs485_drive_enable = uart_tx_busy && !in_reset;

   ////////////////////////////////////////////////////////////////////////////
   // Delay start: leaving HOLD must begin the count from zero
   sequence rg_release_s;
      st_r.rg_state == USRP_RG_HOLD && !in_reset ##1 st_r.rg_state == USRP_RG_WAIT;
   endsequence

   a_mem_float: assert property (@(posedge clk_sys) in_reset |->
      !mem_pins.clk_oe && !mem_pins.sel_oe && !mem_pins.io_oe)
      else $error("memory pins driven in reset");
   a_rg_hiz_reset: assert property (@(posedge clk_sys) disable iff (srst)
      in_reset |=> !reset_gen_out_n_oe) else $error("reset output driven in reset");
   a_rg_start: assert property (@(posedge clk_sys) disable iff (srst)
      rg_release_s |-> st_r.rg_cnt == '0) else $error("reset delay not started from zero");
   a_rg_delay: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(reset_gen_out_n_oe) |-> $past(st_r.rg_cnt) == RG_LAST)
      else $error("reset output early");
   // A host bus reset while driving must leave the output driving
   a_rg_busrst: assert property (@(posedge clk_sys) disable iff (srst)
      usb_bus_reset && reset_gen_out_n_oe && !in_reset |=> reset_gen_out_n_oe)
      else $error("reset output disturbed by bus reset");
   a_sleep_level: assert property (@(posedge clk_sys) sleep_n == !usb_suspended)
      else $error("sleep indicator wrong");
   a_pwr_suspend: assert property (@(posedge clk_sys) disable iff (srst)
      usb_suspended |-> power_enable_n) else $error("power enable low in suspend");
   a_pwr_config: assert property (@(posedge clk_sys) disable iff (in_reset)
      usb_configured && !usb_suspended ##1 !usb_suspended |-> !power_enable_n)
      else $error("power enable not asserted");
   a_wake_resume: assert property (@(posedge clk_sys) disable iff (srst)
      resume_req |-> $past(remote_wake_en) && $past(usb_suspended))
      else $error("resume without wake cause");
   a_tx_lamp: assert property (@(posedge clk_sys) disable iff (srst)
      usb_tx_event |=> tx_activity_led_n_oe [*8]) else $error("tx lamp pulse short");
   a_rx_lamp: assert property (@(posedge clk_sys) disable iff (srst)
      usb_rx_event |=> rx_activity_led_n_oe [*8]) else $error("rx lamp pulse short");
   a_osc_stop: assert property (@(posedge clk_sys) disable iff (srst)
      usb_suspended ##1 usb_suspended |-> !osc_out) else $error("osc toggles in suspend");
   a_strap_mode: assert property (@(posedge clk_sys) disable iff (srst)
      st_r.pwr_strap.val ##1 st_r.pwr_strap.val |-> ##1 self_powered)
      else $error("power strap not adopted");
   a_strap_take: assert property (@(posedge clk_sys) disable iff (srst)
      !in_reset && !st_r.strap_taken |=> clk48_mode != $past(cfg_mem_select_i))
      else $error("clock strap not adopted");
   a_rs485_en: assert property (@(posedge clk_sys) disable iff (in_reset)
      uart_tx_busy |-> rs485_drive_enable) else $error("rs485 enable missing");
endmodule

// ---- include/usrp_pkg.sv ----
// Constants and carrier types for the reset, suspend and pin control block
package usrp_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Reset-generator release delay in microseconds
   localparam int unsigned RSTGEN_DELAY_US = 2000;
   localparam int unsigned RSTGEN_CYCLES = RSTGEN_DELAY_US * (CLK_HZ / 1_000_000);
   // Activity lamp stretch in microseconds
   localparam int unsigned LED_STRETCH_US = 5000;
   localparam int unsigned LED_CYCLES = LED_STRETCH_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 16;

   typedef enum logic [1:0] {
      USRP_RG_HOLD,
      USRP_RG_WAIT,
      USRP_RG_DRIVE
   } usrp_rg_e;

   // Three-stage pin synchroniser
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic val;
   } usrp_sync_s;

   // Pins toward the configuration memory
   typedef struct packed {
      logic sel_o;
      logic sel_oe;
      logic clk_o;
      logic clk_oe;
      logic io_o;
      logic io_oe;
   } usrp_mem_pins_s;

   typedef struct packed {
      usrp_sync_s reset_n;
      usrp_sync_s ring_n;
      usrp_sync_s pwr_strap;
      usrp_sync_s test_in;
      usrp_rg_e rg_state;
      logic [CNT_W-1:0] rg_cnt;
      logic [CNT_W-1:0] tx_cnt;
      logic [CNT_W-1:0] rx_cnt;
      logic strap_taken;
      logic clk48_mode;
      logic self_powered;
      logic configured;
      logic wake_done;
      logic resume_req;
      logic osc_gate;
   } usrp_state_s;
endpackage

// ---- testbench/usrp_board_model.sv ----
// Board and crystal model seen by the reset, suspend and pin block
`timescale 1ns/1ns
module usrp_board_model
   import usrp_pkg::*;
#(
   parameter bit PULL48 = 1'b1,
   parameter bit SELF_PWR = 1'b1
)(
   input usrp_pkg::usrp_mem_pins_s mem_pins,
   output logic sel_pad,
   output logic io_pad,
   output logic strap,
   output logic test_pin,
   output logic osc
);
   // A 10k pull-down on select asks for 48 MHz, else the pad pull-up wins
   assign sel_pad = mem_pins.sel_oe ? mem_pins.sel_o : !PULL48;
   // Released data pad rests high through its pull-up
   assign io_pad = mem_pins.io_oe ? mem_pins.io_o : 1'b1;
   // Supply switched from power enable, so the interface pull-down option is taken as on
   assign strap = SELF_PWR;
   assign test_pin = 1'b0;
   // Free-running 6 MHz crystal, no phase relation to the system clock
   initial begin
      osc = 1'b0;
      forever #83 osc = ~osc;
   end
endmodule

// ---- testbench/usrp_pins_tb.sv ----
// Self-checking bench for the reset, suspend and pin control block
`timescale 1ns/1ns
module usrp_pins_tb;
   import usrp_pkg::*;
   logic clk_sys, srst, ext_reset_n, ring_n, strap, test_pin, susp, conf, bus_rst;
   logic tx_ev, rx_ev, wake_en, drv, io_req, tx_busy, sel_pad, io_pad, osc;
   usrp_mem_pins_s mem_pins;
   logic dev_rst, c48, self_pw, resume, sleep_n, pwr_n, rg_o, rg_oe;
   logic txl_o, txl_oe, rxl_o, rxl_oe, osc_out, rs485, io_rd;
   int errors, n_checks, osc_edges, n, k;

   usrp_board_model board (.mem_pins(mem_pins), .sel_pad(sel_pad), .io_pad(io_pad),
      .strap(strap), .test_pin(test_pin), .osc(osc));
   usrp_pins uut (.clk_sys(clk_sys), .srst(srst), .ext_reset_n(ext_reset_n),
      .ring_indicate_n(ring_n), .power_mode_strap(strap), .cfg_mem_select_i(sel_pad),
      .cfg_mem_io_i(io_pad), .test_mode(test_pin), .osc_in(osc), .usb_suspended(susp),
      .usb_configured(conf), .usb_bus_reset(bus_rst), .usb_tx_event(tx_ev),
      .usb_rx_event(rx_ev), .remote_wake_en(wake_en), .mem_sel_drv(drv),
      .mem_clk_drv(drv), .mem_io_drv(drv), .mem_io_oe_req(io_req),
      .uart_tx_busy(tx_busy), .mem_pins(mem_pins), .cfg_mem_io_rd(io_rd), .device_reset(dev_rst),
      .clk48_mode(c48), .self_powered(self_pw), .resume_req(resume), .sleep_n(sleep_n),
      .power_enable_n(pwr_n), .reset_gen_out_n_o(rg_o), .reset_gen_out_n_oe(rg_oe),
      .tx_activity_led_n_o(txl_o), .tx_activity_led_n_oe(txl_oe),
      .rx_activity_led_n_o(rxl_o), .rx_activity_led_n_oe(rxl_oe), .osc_out(osc_out),
      .rs485_drive_enable(rs485));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Edges are counted rather than sampled, so the crystal phase cannot race the check
   always @(posedge osc_out) osc_edges++;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t mismatch in check %0d", $time, n_checks);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #10;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_rstgen();
      n = 0;
      while (rg_oe !== 1'b1 && n < 20100) begin
         @(posedge clk_sys) bus_rst <= (n == 100);
         #10 n++;
      end
      chk(n >= 20000 && n <= 20010, 1'b1);
      chk(rg_o, 1'b1);
      @(posedge clk_sys) ext_reset_n <= 1'b0;
      cyc(6);
      chk(dev_rst, 1'b1);
      chk(rg_oe, 1'b0);
      chk(mem_pins.clk_oe, 1'b0);
      chk(mem_pins.sel_oe, 1'b0);
      @(posedge clk_sys) ext_reset_n <= 1'b1;
      cyc(6);
      chk(dev_rst, 1'b0);
      chk(rg_oe, 1'b0);
      chk(mem_pins.clk_oe, 1'b1);
   endtask
   task automatic t_power();
      @(posedge clk_sys) conf <= 1'b1;
      tx_busy <= 1'b1;
      cyc(2);
      chk(pwr_n, 1'b0);
      chk(sleep_n, 1'b1);
      chk(rs485, 1'b1);
      n = osc_edges;
      cyc(4);
      chk(osc_edges > n, 1'b1);
      @(posedge clk_sys) susp <= 1'b1;
      tx_busy <= 1'b0;
      cyc(2);
      chk(sleep_n, 1'b0);
      chk(pwr_n, 1'b1);
      chk(rs485, 1'b0);
      n = osc_edges;
      @(posedge clk_sys) wake_en <= 1'b1;
      ring_n <= 1'b0;
      cyc(1);
      k = 0;
      while (resume !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      chk(resume, 1'b1);
      cyc(1);
      chk(resume, 1'b0);
      chk(osc_edges == n, 1'b1);
      @(posedge clk_sys) susp <= 1'b0;
      ring_n <= 1'b1;
      cyc(2);
      chk(sleep_n, 1'b1);
   endtask
   task automatic t_lamps();
      @(posedge clk_sys) tx_ev <= 1'b1;
      rx_ev <= 1'b1;
      @(posedge clk_sys) tx_ev <= 1'b0;
      rx_ev <= 1'b0;
      #10;
      chk(txl_oe & !txl_o, 1'b1);
      chk(rxl_oe & !rxl_o, 1'b1);
      cyc(30000);
      @(posedge clk_sys) bus_rst <= 1'b1;
      @(posedge clk_sys) bus_rst <= 1'b0;
      cyc(1);
      chk(rg_oe, 1'b1);
      cyc(19987);
      chk(txl_oe, 1'b1);
      cyc(20);
      chk(txl_oe, 1'b0);
      chk(rxl_oe, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {errors, n_checks, osc_edges} = '0;
      srst = 1'b1;
      ext_reset_n = 1'b1;
      ring_n = 1'b1;
      {susp, conf, bus_rst, tx_ev, rx_ev, wake_en, io_req, tx_busy} = '0;
      drv = 1'b1;
      cyc(5);
      chk(mem_pins.clk_oe | mem_pins.io_oe | rg_oe, 1'b0);
      @(posedge clk_sys) srst <= 1'b0;
      io_req <= 1'b1;
      t_rstgen();
      chk(c48, 1'b1);
      chk(self_pw, 1'b1);
      chk(mem_pins.io_oe, 1'b1);
      chk(mem_pins.sel_oe, 1'b1);
      @(posedge clk_sys) drv <= 1'b0;
      cyc(1);
      chk(io_rd, 1'b0);
      @(posedge clk_sys) io_req <= 1'b0;
      cyc(1);
      chk(mem_pins.io_oe | !io_rd, 1'b0);
      @(posedge clk_sys) io_req <= 1'b1;
      drv <= 1'b1;
      t_power();
      t_lamps();
      tally_and_finish();
   end
endmodule
